// ===== shared/sep_pkg.sv
// package: constants, states and behaviour summary of the eeprom slave
// What this block does
// - holds 256 eight-bit locations addressed by one address byte
// - select id 1010 in the upper nibble addresses the memory array
// - select id 0110 addresses the protection register instead
// - select bits b3..b1 must equal the three strap inputs
// - device drives acknowledge in the ninth bit of each received byte it accepts
// - start is sda falling while scl stays high
// - start watched always except in write cycle; unstarted traffic ignored
// - stop is sda rising while scl high; it ends communication
// - read ended by not-acknowledge then stop puts device in standby
// - stop closing a write command launches the internal write cycle
// - below supply threshold device is held reset and rejects commands
// - write inhibit low permits writes; high refuses array and register writes
// - with inhibit low, lower half writability follows protection status
// - once protection is set, writes to locations 00h..7Fh are blocked forever
// - sda is open drain only: pulled low or released, never driven high
// - master alone starts transfers and clocks; device is only a slave
// - byte and page writes, at most 16 data bytes per page
// - select acked only on strap match; mismatch deselects to standby
// - after protection is set the 0110 identifier gets no answer
// - received sda is sampled on each rising scl edge
package sep_pkg;

   // --------------------------------------------------------------------
   // array and select byte layout
   // --------------------------------------------------------------------
   localparam int         MEM_DEPTH      = 256;
   localparam int         ADDR_W         = 8;
   localparam int         BYTE_W         = 8;
   localparam int         PAGE_BYTES     = 16;
   localparam int         PAGE_W         = 4;
   localparam int         SEL_ID_HI      = 7;
   localparam int         SEL_ID_LO      = 4;
   localparam int         SEL_CE_HI      = 3;
   localparam int         SEL_CE_LO      = 1;
   localparam int         SEL_RW         = 0;
   localparam int         LOCK_ADDR_BIT  = 7;
   localparam logic [3:0] ID_MEMORY      = 4'hA;
   localparam logic [3:0] ID_PROTECT     = 4'h6;
   localparam logic [7:0] PROT_READ_FILL = 8'hFF;

   // --------------------------------------------------------------------
   // bit slot counter values
   // --------------------------------------------------------------------
   localparam logic [3:0] BIT_ZERO       = 4'h0;
   localparam logic [3:0] BIT_FIRST      = 4'h1;
   localparam logic [3:0] BIT_ACK        = 4'h8;
   localparam logic [3:0] BIT_DONE       = 4'h9;

   // --------------------------------------------------------------------
   // timing
   // --------------------------------------------------------------------
   localparam int         CLK_PERIOD_NS  = 4;
   localparam int         WR_TIME_NS     = 5_000_000;
   localparam int         WR_CYCLES_DFLT =
      (WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // --------------------------------------------------------------------
   // input synchroniser: {supply, inhibit, strap2..0, sda, scl}
   // --------------------------------------------------------------------
   localparam int         SYNC_W         = 7;
   localparam logic [6:0] SYNC_INIT      = 7'h03;

   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b000,
      ST_SEL   = 3'b001,
      ST_ADDR  = 3'b010,
      ST_WRITE = 3'b011,
      ST_READ  = 3'b100,
      ST_BUSY  = 3'b101
   } sep_state_t;

endpackage

// ===== hdl/sep_sync.sv
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module sep_sync
#(
   parameter int              WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // levels
   input  wire logic [WIDTH-1:0]  asyncIn,
   output logic      [WIDTH-1:0]  syncOut
);

   logic [WIDTH-1:0] meta_r;

   // meta_r feeds only the second stage
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_r  <= INIT;
         syncOut <= INIT;
      end
      else
      begin
         meta_r  <= asyncIn;
         syncOut <= meta_r;
      end
   end

endmodule // sep_sync

// ===== hdl/sep_slave_top.sv
// two-wire slave front end of a 256-byte presence-detect eeprom
`timescale 1ns/1ps
module sep_slave_top
   import sep_pkg::*;
#(
   parameter int WR_CYCLES = WR_CYCLES_DFLT
)
(
   // system
   input  wire logic clk,
   input  wire logic rst_n,
   // two-wire link
   input  wire logic sclClk,
   input  wire logic sdaIn,
   output logic      sdaOut,
   output logic      sdaOe,
   // straps and controls
   input  wire logic strapSelectBit0,
   input  wire logic strapSelectBit1,
   input  wire logic strapSelectBit2,
   input  wire logic writeInhibitInput,
   input  wire logic supplyOk,
   // status
   output logic      writeBusy,
   output logic      protectLocked
);

   // --------------------------------------------------------------------
   // elaboration check
   // --------------------------------------------------------------------
   if (WR_CYCLES < 1)
   begin : g_badParam
      $error("WR_CYCLES must be at least one");
   end

   // --------------------------------------------------------------------
   // link domain: receive shifter on the master's clock
   // --------------------------------------------------------------------
   // sda is stable around rising scl by protocol, so it needs no
   // synchroniser here; the shifter is read only while scl is low
   logic [BYTE_W-1:0] rxShift_r;

   always_ff @(posedge sclClk)
   begin
      rxShift_r <= {rxShift_r[BYTE_W-2:0], sdaIn};
   end

   // --------------------------------------------------------------------
   // pin synchronisers and bus events
   // --------------------------------------------------------------------
   logic [SYNC_W-1:0] rawIn;
   logic [SYNC_W-1:0] syncV;
   logic              sclS;
   logic              sdaS;
   logic [2:0]        strapV;
   logic              inhibitS;
   logic              porS;
   logic              sclPrev_r;
   logic              sdaPrev_r;
   logic              sclRise;
   logic              sclFall;
   logic              startEv;
   logic              stopEv;

   assign rawIn = {supplyOk, writeInhibitInput, strapSelectBit2,
                   strapSelectBit1, strapSelectBit0, sdaIn, sclClk};

   sep_sync #(.WIDTH(SYNC_W), .INIT(SYNC_INIT)) u_sync
   (
      .clk     (clk),
      .rst_n   (rst_n),
      .asyncIn (rawIn),
      .syncOut (syncV)
   );

   assign sclS     = syncV[0];
   assign sdaS     = syncV[1];
   assign strapV   = syncV[4:2];
   assign inhibitS = syncV[5];
   assign porS     = syncV[6];

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end
      else
      begin
         sclPrev_r <= sclS;
         sdaPrev_r <= sdaS;
      end
   end

   assign sclRise = sclS & ~sclPrev_r;
   assign sclFall = ~sclS & sclPrev_r;
   assign startEv = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
   assign stopEv  = sclS & sclPrev_r & ~sdaPrev_r & sdaS;

   // --------------------------------------------------------------------
   // state and decode
   // --------------------------------------------------------------------
   sep_state_t              state_r;
   sep_state_t              state_nxt;
   logic [3:0]              bitCnt_r;
   logic [3:0]              bitCnt_nxt;
   logic [ADDR_W-1:0]       addr_r;
   logic [ADDR_W-1:0]       addr_nxt;
   logic [BYTE_W-1:0]       txByte_r;
   logic [BYTE_W-1:0]       txByte_nxt;
   logic                    sdaOe_r;
   logic                    sdaOe_nxt;
   logic                    isRead_r;
   logic                    isRead_nxt;
   logic                    isProt_r;
   logic                    isProt_nxt;
   logic                    lastAck_r;
   logic                    lastAck_nxt;
   logic                    pending_r;
   logic                    pending_nxt;
   logic                    protLock_r;
   logic                    writeBusy_r;
   logic [31:0]             timer_r;
   logic [BYTE_W-1:0]       mem_r [MEM_DEPTH];
   logic [BYTE_W-1:0]       page_r [PAGE_BYTES];
   logic [PAGE_BYTES-1:0]   mask_r;

   logic              byteDone;
   logic              slotDone;
   logic              shiftSlot;
   logic [3:0]        idField;
   logic              ceMatch;
   logic              hitMem;
   logic              hitProt;
   logic              selAck;
   logic              lowLocked;
   logic              wrAllowed;
   logic              bufWr;
   logic              commit;
   logic [BYTE_W-1:0] rdByte;

   assign byteDone  = sclFall & (bitCnt_r == BIT_ACK);
   assign slotDone  = sclFall & (bitCnt_r == BIT_DONE);
   assign shiftSlot = sclFall & (bitCnt_r >= BIT_FIRST)
                    & (bitCnt_r < BIT_ACK);
   assign idField   = rxShift_r[SEL_ID_HI:SEL_ID_LO];
   assign ceMatch   = rxShift_r[SEL_CE_HI:SEL_CE_LO] == strapV;
   assign hitMem    = idField == ID_MEMORY;
   assign hitProt   = (idField == ID_PROTECT) & ~protLock_r;
   assign selAck    = ceMatch & (hitMem | hitProt);
   assign lowLocked = protLock_r & ~addr_r[LOCK_ADDR_BIT];
   assign wrAllowed = ~inhibitS & (isProt_r | ~lowLocked);
   assign bufWr     = porS & byteDone & (state_r == ST_WRITE) & wrAllowed;
   // only a stop in the slot right after an acked data byte programs
   assign commit    = porS & stopEv & (state_r == ST_WRITE) & lastAck_r
                    & (bitCnt_r == BIT_FIRST) & pending_r;
   assign rdByte    = isProt_r ? PROT_READ_FILL : mem_r[addr_r];
   assign sdaOut    = 1'b0;
   assign sdaOe     = sdaOe_r;
   assign writeBusy     = writeBusy_r;
   assign protectLocked = protLock_r;

   // --------------------------------------------------------------------
   // protocol engine, next state
   // --------------------------------------------------------------------
   // the device never clocks the bus; bus steps follow master edges, the write cycle ends on the timer
   always_comb
   begin
      state_nxt   = state_r;
      bitCnt_nxt  = bitCnt_r;
      addr_nxt    = addr_r;
      txByte_nxt  = txByte_r;
      sdaOe_nxt   = sdaOe_r;
      isRead_nxt  = isRead_r;
      isProt_nxt  = isProt_r;
      lastAck_nxt = lastAck_r;
      pending_nxt = pending_r;
      if (!porS)
      begin
         state_nxt   = ST_IDLE;
         bitCnt_nxt  = BIT_ZERO;
         sdaOe_nxt   = 1'b0;
         pending_nxt = 1'b0;
      end
      else if (state_r == ST_BUSY)
      begin
         if (timer_r == '0)
            state_nxt = ST_IDLE;
      end
      else if (startEv)
      begin
         state_nxt   = ST_SEL;
         bitCnt_nxt  = BIT_ZERO;
         sdaOe_nxt   = 1'b0;
         lastAck_nxt = 1'b0;
         pending_nxt = 1'b0;
      end
      else if (stopEv)
      begin
         state_nxt   = commit ? ST_BUSY : ST_IDLE;
         bitCnt_nxt  = BIT_ZERO;
         sdaOe_nxt   = 1'b0;
         pending_nxt = 1'b0;
      end
      else if (state_r != ST_IDLE)
      begin
         if (sclRise && bitCnt_r != BIT_DONE)
            bitCnt_nxt = bitCnt_r + BIT_FIRST;
         // master answer to a read byte, seen at the ninth rising edge
         if (sclRise && state_r == ST_READ && bitCnt_r == BIT_ACK)
         begin
            if (sdaS)
               state_nxt = ST_IDLE;
            else
               addr_nxt = addr_r + ADDR_W'(1);
         end
         if (shiftSlot && state_r == ST_READ)
         begin
            sdaOe_nxt  = ~txByte_r[BYTE_W-2];
            txByte_nxt = {txByte_r[BYTE_W-2:0], 1'b1};
         end
         if (byteDone)
         begin
            case (state_r)
               ST_SEL:
               begin
                  sdaOe_nxt   = selAck;
                  isRead_nxt  = rxShift_r[SEL_RW];
                  isProt_nxt  = hitProt & ~hitMem;
                  lastAck_nxt = selAck;
                  if (!selAck)
                     state_nxt = ST_IDLE;
               end
               ST_ADDR:
               begin
                  sdaOe_nxt = 1'b1;
                  addr_nxt  = rxShift_r;
               end
               ST_WRITE:
               begin
                  sdaOe_nxt   = wrAllowed;
                  lastAck_nxt = wrAllowed;
                  if (wrAllowed)
                  begin
                     pending_nxt = 1'b1;
                     addr_nxt    = {addr_r[ADDR_W-1:PAGE_W],
                                    addr_r[PAGE_W-1:0] + PAGE_W'(1)};
                  end
               end
               default:
                  sdaOe_nxt = 1'b0;
            endcase
         end
         if (slotDone)
         begin
            bitCnt_nxt = BIT_ZERO;
            sdaOe_nxt  = 1'b0;
            case (state_r)
               ST_SEL:
                  state_nxt = isRead_r ? ST_READ : ST_ADDR;
               ST_ADDR:
                  state_nxt = ST_WRITE;
               default:
                  state_nxt = state_r;
            endcase
            // first bit of the next read byte goes out while scl is low
            if ((state_r == ST_SEL && isRead_r) || state_r == ST_READ)
            begin
               txByte_nxt = rdByte;
               sdaOe_nxt  = ~rdByte[BYTE_W-1];
            end
         end
      end
   end

   // --------------------------------------------------------------------
   // engine registers
   // --------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_r     <= ST_IDLE;
         bitCnt_r    <= BIT_ZERO;
         addr_r      <= '0;
         txByte_r    <= '0;
         sdaOe_r     <= 1'b0;
         isRead_r    <= 1'b0;
         isProt_r    <= 1'b0;
         lastAck_r   <= 1'b0;
         pending_r   <= 1'b0;
         writeBusy_r <= 1'b0;
      end
      else
      begin
         state_r     <= state_nxt;
         bitCnt_r    <= bitCnt_nxt;
         addr_r      <= addr_nxt;
         txByte_r    <= txByte_nxt;
         sdaOe_r     <= sdaOe_nxt;
         isRead_r    <= isRead_nxt;
         isProt_r    <= isProt_nxt;
         lastAck_r   <= lastAck_nxt;
         pending_r   <= pending_nxt;
         writeBusy_r <= state_nxt == ST_BUSY;
      end
   end

   // --------------------------------------------------------------------
   // write cycle timer and protection latch
   // --------------------------------------------------------------------
   // the lock models a nonvolatile bit; only a full logic reset clears it
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         timer_r    <= '0;
         protLock_r <= 1'b0;
      end
      else
      begin
         if (commit)
            timer_r <= 32'(WR_CYCLES - 1);
         else if (timer_r != '0)
            timer_r <= timer_r - 32'h0000_0001;
         if (commit && isProt_r)
            protLock_r <= 1'b1;
      end
   end

   // --------------------------------------------------------------------
   // page latches and array
   // --------------------------------------------------------------------
   // bytes gather in the page latches and reach the array only on commit
   always_ff @(posedge clk)
   begin
      if (!rst_n || startEv)
         mask_r <= '0;
      else if (bufWr)
      begin
         mask_r[addr_r[PAGE_W-1:0]] <= 1'b1;
         page_r[addr_r[PAGE_W-1:0]] <= rxShift_r;
      end
   end

   always_ff @(posedge clk)
   begin
      if (commit && !isProt_r)
      begin
         for (int i = 0; i < PAGE_BYTES; i++)
         begin
            if (mask_r[i])
               mem_r[{addr_r[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_r[i];
         end
      end
   end

   // --------------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_busyQuiet;
      state_r == ST_BUSY |-> !sdaOe;
   endproperty
   a_busyQuiet: assert property (p_busyQuiet)
      else $error("bus driven during write cycle");

   property p_porHold;
      !porS |=> state_r == ST_IDLE && !sdaOe;
   endproperty
   a_porHold: assert property (p_porHold)
      else $error("engine active below supply threshold");

   property p_selMismatch;
      byteDone && state_r == ST_SEL && !ceMatch
         |=> !sdaOe && state_r == ST_IDLE;
   endproperty
   a_selMismatch: assert property (p_selMismatch)
      else $error("mismatched select not dropped");

   property p_selAck;
      porS && byteDone && state_r == ST_SEL && selAck |=> sdaOe;
   endproperty
   a_selAck: assert property (p_selAck)
      else $error("matching select not acknowledged");

   property p_inhibit;
      porS && byteDone && state_r == ST_WRITE && inhibitS
         |=> !sdaOe && pending_r == $past(pending_r);
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("write accepted while inhibited");

   property p_lockSticky;
      protLock_r |=> protLock_r;
   endproperty
   a_lockSticky: assert property (p_lockSticky)
      else $error("protection lock released");

   property p_commitBusy;
      commit |=> state_r == ST_BUSY && writeBusy;
   endproperty
   a_commitBusy: assert property (p_commitBusy)
      else $error("stop after write did not start write cycle");

   property p_pageWrap;
      bufWr |=> addr_r[ADDR_W-1:PAGE_W] == $past(addr_r[ADDR_W-1:PAGE_W])
         && addr_r[PAGE_W-1:0] == $past(addr_r[PAGE_W-1:0]) + PAGE_W'(1);
   endproperty
   a_pageWrap: assert property (p_pageWrap)
      else $error("page address left its page");

   property p_startSeen;
      porS && startEv && state_r != ST_BUSY
         |=> state_r == ST_SEL && bitCnt_r == BIT_ZERO && !sdaOe;
   endproperty
   a_startSeen: assert property (p_startSeen)
      else $error("start not recognised");

   property p_protHidden;
      byteDone && state_r == ST_SEL && protLock_r
         && idField == ID_PROTECT |=> !sdaOe;
   endproperty
   a_protHidden: assert property (p_protHidden)
      else $error("locked protection id answered");

   property p_readNack;
      porS && sclRise && state_r == ST_READ && bitCnt_r == BIT_ACK && sdaS
         |=> state_r == ST_IDLE ##1 !sdaOe;
   endproperty
   a_readNack: assert property (p_readNack)
      else $error("not-acknowledged read kept going");

endmodule // sep_slave_top

// ===== sim/sep_master.sv
// two-wire bus master model for the eeprom slave bench
`timescale 1ns/1ps
module sep_master
(
   // link
   output logic       sclClk,
   output logic       sdaLow,
   input  wire logic  sdaWire,
   // observed ack bits and read bytes
   output logic [7:0] seenVal,
   output logic       seenStb
);
   logic tick;
   // 12 ns step, unrelated in phase; scl stands still between frames
   initial
   begin
      tick = 1'b0;
      sclClk = 1'b1;
      sdaLow = 1'b0;
      seenVal = 8'h00;
      seenStb = 1'b0;
      #5;
      forever #6 tick = ~tick;
   end
   task automatic w(input int n);
      repeat (n) @(posedge tick);
   endtask
   // sda moves only while scl low; two steps make a 24 ns phase
   task automatic bit_io(input logic b, output logic r);
      sdaLow = ~b;
      w(2);
      sclClk = 1'b1;
      w(2);
      r = sdaWire;
      sclClk = 1'b0;
   endtask
   task automatic start;
      sdaLow = 1'b0;
      w(2);
      sclClk = 1'b1;
      w(2);
      sdaLow = 1'b1;
      w(2);
      sclClk = 1'b0;
   endtask
   task automatic stop;
      sdaLow = 1'b1;
      w(2);
      sclClk = 1'b1;
      w(2);
      sdaLow = 1'b0;
      w(2);
   endtask
   task automatic post(input logic [7:0] v);
      seenVal = v;
      seenStb = 1'b1;
      w(1);
      seenStb = 1'b0;
   endtask
   // ack seen is posted as 0, not-acknowledge as 1
   task automatic send(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      post({7'h00, r});
   endtask
   task automatic recv(input logic ack);
      logic [7:0] v;
      logic       r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
      bit_io(~ack, r);
      post(v);
   endtask
endmodule // sep_master

// ===== sim/tb.sv
// self-checking bench for the eeprom slave front end
`timescale 1ns/1ps
module tb
   import sep_pkg::*;
;
   localparam int WRC = 40;
   logic       clk;
   logic       rst_n;
   logic       sclClk;
   logic       sdaLow;
   logic       sdaOut;
   logic       sdaOe;
   logic       sdaWire;
   logic [2:0] ce;
   logic       inhibit;
   logic       supplyOk;
   logic       writeBusy;
   logic       protectLocked;
   logic [7:0] seenVal;
   logic       seenStb;
   logic [7:0] mem [256];
   logic [7:0] expQ [$];
   int         fails = 0;
   int         comparisons = 0;
   int         seed = 20;
   // pull-up: low only while a party pulls
   assign sdaWire = ~((sdaOe & ~sdaOut) | sdaLow);
   sep_slave_top #(.WR_CYCLES(WRC)) sep_slave_top_i
   (
      .clk(clk), .rst_n(rst_n), .sclClk(sclClk), .sdaIn(sdaWire),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .strapSelectBit0(ce[0]),
      .strapSelectBit1(ce[1]), .strapSelectBit2(ce[2]),
      .writeInhibitInput(inhibit), .supplyOk(supplyOk),
      .writeBusy(writeBusy), .protectLocked(protectLocked)
   );
   sep_master sep_master_i
   (
      .sclClk(sclClk), .sdaLow(sdaLow), .sdaWire(sdaWire),
      .seenVal(seenVal), .seenStb(seenStb)
   );
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want)
      begin
         fails++;
         $display("wrong value at %0t: %h expected %h", $time, seen, want);
      end
   endtask
   task automatic print_verdict;
      // an expected result that never appeared is a mismatch too
      if (expQ.size() != 0)
         fails++;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic snd(input logic [7:0] b, input logic nak);
      expQ.push_back({7'h00, nak});
      sep_master_i.send(b);
   endtask
   function automatic logic [7:0] sel(input logic [3:0] id, input logic r);
      return {id, ce, r};
   endfunction
   // write n random bytes from a; data answered with nak
   task automatic wrt(input logic [3:0] id, input logic [7:0] a,
                      input int n, input logic nak);
      logic [7:0] d;
      sep_master_i.start();
      snd(sel(id, 1'b0), 1'b0);
      snd(a, 1'b0);
      for (int k = 0; k < n; k++)
      begin
         d = 8'($random(seed));
         snd(d, nak);
         if (!nak && id == ID_MEMORY) mem[{a[7:4], a[3:0] + k[3:0]}] = d;
      end
   endtask
   task automatic rd(input logic [7:0] a, input int n);
      wrt(ID_MEMORY, a, 0, 1'b0);
      sep_master_i.start();
      snd(sel(ID_MEMORY, 1'b1), 1'b0);
      for (int k = 0; k < n; k++)
      begin
         expQ.push_back(mem[a + k[7:0]]);
         sep_master_i.recv(k < n - 1);
      end
      sep_master_i.stop();
   endtask
   // busy is seen as a level anywhere in the poll window
   task automatic commit(input logic want);
      logic seen;
      seen = 1'b0;
      sep_master_i.stop();
      repeat (WRC + 20) @(negedge clk) seen = seen | writeBusy;
      check({7'h00, seen}, {7'h00, want});
   endtask
   always @(posedge seenStb)
      if (expQ.size() > 0)
         check(seenVal, expQ.pop_front());
      else
         fails++;
   always @(negedge clk)
      if (sdaOe === 1'b1)
         check({7'h00, sdaOut}, 8'h00);
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // traffic is about 30 us; far beyond that is a hang
   initial
   begin
      #250_000;
      fails++;
      print_verdict();
   end
   initial
   begin
      rst_n = 1'b0;
      supplyOk = 1'b0;
      inhibit = 1'b0;
      ce = 3'($random(seed));
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      sep_master_i.start();
      snd(sel(ID_MEMORY, 1'b0), 1'b1);
      sep_master_i.stop();
      @(negedge clk) supplyOk = 1'b1;
      repeat (6) @(negedge clk);
      sep_master_i.start();
      snd({ID_MEMORY, ~ce, 1'b0}, 1'b1);
      sep_master_i.start();
      snd(sel(4'h5, 1'b0), 1'b1);
      sep_master_i.stop();
      wrt(ID_MEMORY, 8'h10, 1, 1'b0);
      commit(1'b1);
      // 17 bytes from 9eh: the last one overwrites the first
      wrt(ID_MEMORY, 8'h9e, 17, 1'b0);
      sep_master_i.stop();
      sep_master_i.start();
      snd(sel(ID_MEMORY, 1'b0), 1'b1);
      sep_master_i.stop();
      repeat (WRC) @(negedge clk);
      rd(8'h90, 16);
      rd(8'h10, 1);
      @(negedge clk) inhibit = 1'b1;
      wrt(ID_MEMORY, 8'ha0, 1, 1'b1);
      commit(1'b0);
      @(negedge clk) inhibit = 1'b0;
      // protection register read before the lock is set
      sep_master_i.start();
      snd(sel(ID_PROTECT, 1'b1), 1'b0);
      expQ.push_back(PROT_READ_FILL);
      sep_master_i.recv(1'b0);
      sep_master_i.stop();
      wrt(ID_PROTECT, 8'h00, 1, 1'b0);
      commit(1'b1);
      check({7'h00, protectLocked}, 8'h01);
      wrt(ID_MEMORY, 8'h10, 1, 1'b1);
      commit(1'b0);
      sep_master_i.start();
      snd(sel(ID_PROTECT, 1'b1), 1'b1);
      sep_master_i.stop();
      rd(8'h10, 1);
      print_verdict();
   end
endmodule // tb
